// ==== logic/dma_pkg.sv ====
// Package of constants for the drive operation-mode arbiter.
// Assumes a single 25 MHz system clock and an AXI4-Lite register bus.
// What this block does
// - Network switch only at stop, settings 0,2,7
// - Setting 6 switches modes while running
// - Panel/network switch on panel, off network
// - Settings 1,2,3/4 fix panel, external/network, combined
// - Setting 7, interlock off forces external
// - Setting 7, interlock on stops external drive
// - External/network switch on network, off external
// - Setting 7 external/network switching needs interlock
// - Setting 2 with switch refuses panel mode
// - No option and source 0: panel replaces network
// - Panel/external switch off panel, on external
// - Asserted external/network switch forces network
// - Panel/network switch overrides panel/external switch
// - Fixed priority among all mode sources
// - Setting 3: run from terminals, frequency from panel
// - Halt terminal acts as interlock when unassigned
package dma_pkg;

  typedef enum logic [3:0] {
    DMA_EXT = 4'h1,
    DMA_PANEL = 4'h2,
    DMA_NET = 4'h4,
    DMA_COMB = 4'h8
  } dma_mode_t;

  // Register byte offsets.
  localparam logic [7:0] DMA_OFF_MODE_SEL = 8'h00;
  localparam logic [7:0] DMA_OFF_COMM_START = 8'h04;
  localparam logic [7:0] DMA_OFF_NET_SRC = 8'h08;
  localparam logic [7:0] DMA_OFF_ASSIGN = 8'h0c;
  localparam logic [7:0] DMA_OFF_STATUS = 8'h10;

  // Assignment register bit positions.
  localparam int DMA_BIT_ASN_PANEL_NET = 0;
  localparam int DMA_BIT_ASN_EXT_NET = 1;
  localparam int DMA_BIT_ASN_PANEL_EXT = 2;
  localparam int DMA_BIT_ASN_INTERLOCK = 3;
  localparam int DMA_BIT_OPTION_FITTED = 4;

  // Reset values.
  localparam logic [7:0] DMA_RST_MODE_SEL = 8'h00;
  localparam logic [7:0] DMA_RST_COMM_START = 8'h00;
  localparam logic [7:0] DMA_RST_NET_SRC = 8'h00;
  localparam logic [4:0] DMA_RST_ASSIGN = 5'h00;

  // Status register bit positions.
  localparam int DMA_BIT_ST_MODE = 0;
  localparam int DMA_BIT_ST_OUT_STOP = 4;
  localparam int DMA_BIT_ST_RUN_TERM = 5;
  localparam int DMA_BIT_ST_FREQ_PANEL = 6;

  localparam logic [1:0] DMA_RESP_OKAY = 2'h0;
  localparam logic [1:0] DMA_RESP_SLVERR = 2'h2;

endpackage : dma_pkg

// ==== logic/dma_cfg_if.sv ====
// Interface carrying the settings from the register file to the mode logic.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
`default_nettype none
interface dma_cfg_if;
  logic [7:0] mode_select_setting;
  logic [7:0] comm_startup_setting;
  logic [7:0] network_cmd_source_setting;
  logic [4:0] assign_bits;
  dma_pkg::dma_mode_t mode;
  logic output_stop;
  logic run_from_terminals;
  logic freq_from_panel;
  modport regs (output mode_select_setting, comm_startup_setting,
                network_cmd_source_setting, assign_bits,
                input mode, output_stop, run_from_terminals, freq_from_panel);
  modport core (input mode_select_setting, comm_startup_setting,
                network_cmd_source_setting, assign_bits,
                output mode, output_stop, run_from_terminals, freq_from_panel);
endinterface : dma_cfg_if
`default_nettype wire

// ==== logic/dma_regs.sv ====
// AXI4-Lite register slave holding the drive-mode settings.
// Assumes one write and one read at a time from the master.
`timescale 1ns/10ps
`default_nettype none
module dma_regs (
  input wire logic clk_i,
  input wire logic nrst_i,
  // Write channels.
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // Read channels.
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Settings.
  dma_cfg_if.regs cfg
);
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane;
  logic [7:0] mode_sel;
  logic [7:0] comm_start;
  logic [7:0] net_src;
  logic [4:0] asn;
  logic do_write;
  logic wr_hit;

  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o = !w_held && !bvalid_o;
  assign arready_o = !rvalid_o;
  assign do_write = aw_held && w_held && !bvalid_o;

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_write) begin
      aw_held <= 1'b0;
    end else if (awvalid_i && awready_o) begin
      aw_held <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (awvalid_i && awready_o) begin
      aw_addr <= awaddr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || do_write) begin
      w_held <= 1'b0;
    end else if (wvalid_i && wready_o) begin
      w_held <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wvalid_i && wready_o) begin
      w_data <= wdata_i;
      w_lane <= wstrb_i[0];
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    unique case (aw_addr)
      dma_pkg::DMA_OFF_MODE_SEL, dma_pkg::DMA_OFF_COMM_START,
      dma_pkg::DMA_OFF_NET_SRC, dma_pkg::DMA_OFF_ASSIGN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Only byte lane 0 carries setting bits, so its strobe gates the store.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_sel <= dma_pkg::DMA_RST_MODE_SEL;
      comm_start <= dma_pkg::DMA_RST_COMM_START;
      net_src <= dma_pkg::DMA_RST_NET_SRC;
      asn <= dma_pkg::DMA_RST_ASSIGN;
    end else if (do_write && w_lane) begin
      if (aw_addr == dma_pkg::DMA_OFF_MODE_SEL) begin
        mode_sel <= w_data[7:0];
      end
      if (aw_addr == dma_pkg::DMA_OFF_COMM_START) begin
        comm_start <= w_data[7:0];
      end
      if (aw_addr == dma_pkg::DMA_OFF_NET_SRC) begin
        net_src <= w_data[7:0];
      end
      if (aw_addr == dma_pkg::DMA_OFF_ASSIGN) begin
        asn <= w_data[4:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bvalid_o <= 1'b0;
      bresp_o <= dma_pkg::DMA_RESP_OKAY;
    end else if (do_write) begin
      bvalid_o <= 1'b1;
      bresp_o <= wr_hit ? dma_pkg::DMA_RESP_OKAY : dma_pkg::DMA_RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
      rresp_o <= dma_pkg::DMA_RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_o <= 1'b1;
      rresp_o <= dma_pkg::DMA_RESP_OKAY;
      unique case (araddr_i)
        dma_pkg::DMA_OFF_MODE_SEL: rdata_o <= {24'h0, mode_sel};
        dma_pkg::DMA_OFF_COMM_START: rdata_o <= {24'h0, comm_start};
        dma_pkg::DMA_OFF_NET_SRC: rdata_o <= {24'h0, net_src};
        dma_pkg::DMA_OFF_ASSIGN: rdata_o <= {27'h0, asn};
        dma_pkg::DMA_OFF_STATUS: rdata_o <= {25'h0, cfg.freq_from_panel,
                                             cfg.run_from_terminals, cfg.output_stop,
                                             cfg.mode};
        default: begin
          rdata_o <= 32'h0;
          rresp_o <= dma_pkg::DMA_RESP_SLVERR;
        end
      endcase
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

  assign cfg.mode_select_setting = mode_sel;
  assign cfg.comm_startup_setting = comm_start;
  assign cfg.network_cmd_source_setting = net_src;
  assign cfg.assign_bits = asn;

endmodule : dma_regs
`default_nettype wire

// ==== logic/dma_top.sv ====
// Top of the drive operation-mode arbiter: register slave plus mode selection.
// Assumes terminal signals are already synchronous to MCLK_I.
`timescale 1ns/10ps
`default_nettype none
module dma_top (
  // Clock and reset.
  input wire logic MCLK_I,
  input wire logic NRST_I,
  // AXI4-Lite write.
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read.
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Terminal signals.
  input wire logic PANEL_NET_SWITCH_I,
  input wire logic EXT_NET_SWITCH_I,
  input wire logic PANEL_EXT_SWITCH_I,
  input wire logic PANEL_INTERLOCK_I,
  input wire logic DRIVE_HALT_SIGNAL_I,
  input wire logic FORWARD_RUN_CMD_I,
  input wire logic REVERSE_RUN_CMD_I,
  input wire logic MOTOR_STOPPED_I,
  // Mode outputs.
  output logic [3:0] MODE_O,
  output logic OUTPUT_STOP_O,
  output logic RUN_FROM_TERMINALS_O,
  output logic FREQ_FROM_PANEL_O
);
  dma_cfg_if cfg ();
  dma_pkg::dma_mode_t mode;
  dma_pkg::dma_mode_t next_mode;
  dma_pkg::dma_mode_t want;
  logic [7:0] msel;
  logic [7:0] csu;
  logic asn_pn;
  logic asn_en;
  logic asn_pe;
  logic asn_il;
  logic option_fitted;
  logic interlock;
  logic stopped;
  logic pn_active;
  logic en_active;
  logic sel_0_6;
  logic net_lock;
  logic halted_out;

  dma_regs u_regs (
    .clk_i(MCLK_I),
    .nrst_i(NRST_I),
    .awaddr_i(AWADDR_I),
    .awvalid_i(AWVALID_I),
    .awready_o(AWREADY_O),
    .wdata_i(WDATA_I),
    .wstrb_i(WSTRB_I),
    .wvalid_i(WVALID_I),
    .wready_o(WREADY_O),
    .bresp_o(BRESP_O),
    .bvalid_o(BVALID_O),
    .bready_i(BREADY_I),
    .araddr_i(ARADDR_I),
    .arvalid_i(ARVALID_I),
    .arready_o(ARREADY_O),
    .rdata_o(RDATA_O),
    .rresp_o(RRESP_O),
    .rvalid_o(RVALID_O),
    .rready_i(RREADY_I),
    .cfg(cfg.regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings.

  assign msel = cfg.mode_select_setting;
  assign csu = cfg.comm_startup_setting;
  assign asn_pn = cfg.assign_bits[dma_pkg::DMA_BIT_ASN_PANEL_NET];
  assign asn_en = cfg.assign_bits[dma_pkg::DMA_BIT_ASN_EXT_NET];
  assign asn_pe = cfg.assign_bits[dma_pkg::DMA_BIT_ASN_PANEL_EXT];
  assign asn_il = cfg.assign_bits[dma_pkg::DMA_BIT_ASN_INTERLOCK];
  assign option_fitted = cfg.assign_bits[dma_pkg::DMA_BIT_OPTION_FITTED];

  // The halt terminal doubles as interlock when no interlock terminal exists.
  assign interlock = asn_il ? PANEL_INTERLOCK_I : DRIVE_HALT_SIGNAL_I;

  // Stopped means motor halted or no run command present.
  assign stopped = MOTOR_STOPPED_I || !(FORWARD_RUN_CMD_I || REVERSE_RUN_CMD_I);

  // Panel/network switch picks panel or network only when assigned under settings 0/6 and 10/12.
  assign sel_0_6 = (msel == 8'h00) || (msel == 8'h06);
  assign pn_active = asn_pn && sel_0_6 && ((csu == 8'h0a) || (csu == 8'h0c));

  // External/network switch counts only when assigned under 0,2,6,7 and 0..2.
  assign en_active = asn_en && (sel_0_6 || msel == 8'h02 || msel == 8'h07) &&
                     (csu <= 8'h02);

  ////////////////////////////////////////////////////////////////////////////
  // Mode wanted by the settings and signals, in priority order.

  always_comb begin
    want = mode;
    if (msel == 8'h01) begin
      want = dma_pkg::DMA_PANEL;
    end else if (msel == 8'h03 || msel == 8'h04) begin
      want = dma_pkg::DMA_COMB;
    end else if (msel == 8'h02 && !en_active) begin
      want = (pn_active || csu == 8'h0a || csu == 8'h0c) ? dma_pkg::DMA_NET
                                                         : dma_pkg::DMA_EXT;
    end else if (msel == 8'h07 && !interlock) begin
      want = dma_pkg::DMA_EXT;
    end else if (en_active) begin
      if (EXT_NET_SWITCH_I) begin
        want = dma_pkg::DMA_NET;
      end else if (asn_pn && PANEL_NET_SWITCH_I && msel != 8'h02) begin
        want = dma_pkg::DMA_PANEL;
      end else if (!asn_pn && asn_pe && !PANEL_EXT_SWITCH_I && msel != 8'h02) begin
        want = dma_pkg::DMA_PANEL;
      end else begin
        want = dma_pkg::DMA_EXT;
      end
    end else if (pn_active) begin
      want = PANEL_NET_SWITCH_I ? dma_pkg::DMA_PANEL : dma_pkg::DMA_NET;
    end else if (asn_pe) begin
      want = PANEL_EXT_SWITCH_I ? dma_pkg::DMA_EXT : dma_pkg::DMA_PANEL;
    end else if (csu == 8'h0a || csu == 8'h0c || csu == 8'h01 || csu == 8'h02) begin
      want = dma_pkg::DMA_NET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop gating and network substitution.

  assign net_lock = !(msel == 8'h06 || stopped);

  always_comb begin
    next_mode = mode;
    if (msel == 8'h07 && !interlock) begin
      next_mode = dma_pkg::DMA_EXT;
    end else if (msel == 8'h01 || msel == 8'h03 || msel == 8'h04) begin
      next_mode = want;
    end else if (want != mode && !net_lock) begin
      next_mode = want;
    end
    if (next_mode == dma_pkg::DMA_NET && cfg.network_cmd_source_setting == 8'h00 &&
        !option_fitted) begin
      next_mode = dma_pkg::DMA_PANEL;
    end
    if (msel == 8'h02 && next_mode == dma_pkg::DMA_PANEL) begin
      next_mode = mode;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      mode <= dma_pkg::DMA_EXT;
    end else begin
      mode <= next_mode;
    end
  end

  // Under setting 7 an asserted interlock stops drive power in external mode.
  assign halted_out = (msel == 8'h07) && interlock && (mode == dma_pkg::DMA_EXT);

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      OUTPUT_STOP_O <= 1'b0;
      RUN_FROM_TERMINALS_O <= 1'b1;
      FREQ_FROM_PANEL_O <= 1'b0;
    end else begin
      OUTPUT_STOP_O <= halted_out;
      RUN_FROM_TERMINALS_O <= (next_mode == dma_pkg::DMA_EXT) ||
                              (next_mode == dma_pkg::DMA_COMB && msel == 8'h03);
      FREQ_FROM_PANEL_O <= (next_mode == dma_pkg::DMA_PANEL) ||
                           (next_mode == dma_pkg::DMA_COMB && msel == 8'h03);
    end
  end

  assign MODE_O = mode;
  assign cfg.mode = mode;
  assign cfg.output_stop = OUTPUT_STOP_O;
  assign cfg.run_from_terminals = RUN_FROM_TERMINALS_O;
  assign cfg.freq_from_panel = FREQ_FROM_PANEL_O;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_running;
    !stopped && msel != 8'h06;
  endsequence

  a_net_stop_gate: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    s_running and mode != dma_pkg::DMA_NET and msel == 8'h00 |=> mode != dma_pkg::DMA_NET)
    else $error("network mode entered while running");

  a_forced_ext: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    msel == 8'h07 && !interlock |=> mode == dma_pkg::DMA_EXT)
    else $error("setting 7 without interlock did not force external");

  a_fixed_panel: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    msel == 8'h01 |=> mode == dma_pkg::DMA_PANEL)
    else $error("setting 1 did not hold panel mode");

  a_fixed_comb: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    msel == 8'h03 || msel == 8'h04 |=> mode == dma_pkg::DMA_COMB)
    else $error("setting 3 or 4 did not hold combined mode");

  a_no_panel_two: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    msel == 8'h02 && $past(msel) == 8'h02 && mode != dma_pkg::DMA_PANEL
      |=> mode != dma_pkg::DMA_PANEL)
    else $error("setting 2 entered panel mode");

  a_out_stop: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    halted_out |=> OUTPUT_STOP_O)
    else $error("output stop missing under interlock in external mode");

  a_net_subst: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    cfg.network_cmd_source_setting == 8'h00 && !option_fitted && msel != 8'h02
      |=> mode != dma_pkg::DMA_NET)
    else $error("network mode chosen without option fitted");

  a_switch_run: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    msel == 8'h06 && pn_active && !en_active && PANEL_NET_SWITCH_I
      |=> mode == dma_pkg::DMA_PANEL)
    else $error("setting 6 did not switch to panel");

  a_comb_split: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    msel == 8'h03 ##1 msel == 8'h03 |=> RUN_FROM_TERMINALS_O && FREQ_FROM_PANEL_O)
    else $error("setting 3 source split wrong");

endmodule : dma_top
`default_nettype wire

// ==== tb/dma_term_model.sv ====
// Terminal and panel side model: registers requested switch levels onto the terminals.
// Assumes the bench changes the requested levels just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module dma_term_model (
  // Clock.
  input wire logic clk_i,
  // Requested levels.
  input wire logic [7:0] value_i,
  // Terminal levels.
  output logic [7:0] term_o
);
  initial term_o = 8'h80;
  // Switches move only on a clock edge, like debounced terminal inputs.
  always @(posedge clk_i) begin
    term_o <= value_i;
  end
endmodule // dma_term_model
`default_nettype wire

// ==== tb/dma_top_tb_top.sv ====
// Self-checking bench for the drive mode arbiter with a reference model.
// Assumes the logic/ files and the terminal model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dma_top_tb_top;
  logic clk, nrst, awv, wv, br, arv, rr, awr, wr, bv, arr, rv, ostop, rterm, fpan;
  logic [7:0] awa, ara, tv, t;
  logic [31:0] wd, rd;
  logic [3:0] ws, mode;
  logic [1:0] bresp, rresp;
  logic [31:0] seed = 32'hb1c1cdf4;
  int n_errors = 0;
  int tests_run = 0;
  int ms_tab[7] = '{0, 1, 2, 3, 4, 6, 7};
  int cs_tab[5] = '{0, 1, 2, 10, 12};

  dma_top dma_top_inst (.MCLK_I(clk), .NRST_I(nrst), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wr),
    .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(br), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rr),
    .PANEL_NET_SWITCH_I(t[0]), .EXT_NET_SWITCH_I(t[1]), .PANEL_EXT_SWITCH_I(t[2]),
    .PANEL_INTERLOCK_I(t[3]), .DRIVE_HALT_SIGNAL_I(t[4]), .FORWARD_RUN_CMD_I(t[5]),
    .REVERSE_RUN_CMD_I(t[6]), .MOTOR_STOPPED_I(t[7]), .MODE_O(mode),
    .OUTPUT_STOP_O(ostop), .RUN_FROM_TERMINALS_O(rterm), .FREQ_FROM_PANEL_O(fpan));
  dma_term_model dma_term_model_inst (.clk_i(clk), .value_i(tv), .term_o(t));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected mode for a stopped motor, highest priority source first.
  function automatic logic [3:0] ref_mode(input int ms, input int cs, input int ns,
                                          input int asn, input logic [7:0] v);
    logic il;
    logic [3:0] m;
    il = asn[3] ? v[3] : v[4];
    m = dma_pkg::DMA_EXT;
    if (ms == 1) m = dma_pkg::DMA_PANEL;
    else if (ms == 3 || ms == 4) m = dma_pkg::DMA_COMB;
    else if (ms == 7 && !il) m = dma_pkg::DMA_EXT;
    else if (asn[1] && cs <= 2) begin
      if (v[1]) m = dma_pkg::DMA_NET;
      else if (asn[0] && ms != 2) m = v[0] ? dma_pkg::DMA_PANEL : dma_pkg::DMA_EXT;
      else if (asn[2] && ms != 2) m = v[2] ? dma_pkg::DMA_EXT : dma_pkg::DMA_PANEL;
    end
    else if (asn[0] && cs >= 10) m = v[0] ? dma_pkg::DMA_PANEL : dma_pkg::DMA_NET;
    else if (asn[2] && ms != 2) m = v[2] ? dma_pkg::DMA_EXT : dma_pkg::DMA_PANEL;
    if (m == dma_pkg::DMA_NET && ns == 0 && !asn[4]) m = dma_pkg::DMA_PANEL;
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic chk_mode(input logic [3:0] g, input logic [3:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: mode %h, expected %h", $time, g, e);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    r = 2'h3;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv;
      r = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) br <= 1'b0;
    end
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rd;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) rr <= 1'b0;
    end
  endtask

  task automatic setup(input int ms, input int cs, input int ns, input int asn);
    logic [1:0] r;
    bus_wr(dma_pkg::DMA_OFF_MODE_SEL, 32'(ms), r);
    bus_wr(dma_pkg::DMA_OFF_COMM_START, 32'(cs), r);
    bus_wr(dma_pkg::DMA_OFF_NET_SRC, 32'(ns), r);
    bus_wr(dma_pkg::DMA_OFF_ASSIGN, 32'(asn), r);
  endtask

  task automatic chk_cfg(input int ms, input int cs, input int ns, input int asn,
                         input logic [7:0] v);
    logic [3:0] e;
    logic st;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    tv <= v;
    repeat (3) @(posedge clk);
    e = ref_mode(ms, cs, ns, asn, v);
    st = (ms == 7) && (asn[3] ? v[3] : v[4]) && (e == dma_pkg::DMA_EXT);
    @(negedge clk);
    chk_mode(mode, e);
    chk_val({31'h0, ostop}, {31'h0, st});
    if (ms == 3) chk_val({30'h0, rterm, fpan}, 32'h3);
    bus_rd(dma_pkg::DMA_OFF_STATUS, d, r);
    chk_val({27'h0, d[4:0]}, {27'h0, st, e});
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    int ms, cs, ns, asn;
    logic [31:0] x, d;
    logic [7:0] v;
    logic [1:0] r;
    {nrst, awv, wv, br, arv, rr, awa, ara, wd} = '0;
    ws = 4'hf;
    tv = 8'h80;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk_mode(mode, dma_pkg::DMA_EXT);
    chk_val({29'h0, ostop, rterm, fpan}, 32'h2);
    for (int a = 0; a < 5; a++) begin
      bus_rd(8'(4 * a), d, r);
      chk_val(d, (a == 4) ? 32'h21 : 32'h0);
    end
    bus_wr(8'h40, 32'h5, r);
    chk_val({30'h0, r}, {30'h0, dma_pkg::DMA_RESP_SLVERR});
    bus_rd(8'h40, d, r);
    chk_val({d[29:0], r}, {30'h0, dma_pkg::DMA_RESP_SLVERR});
    bus_wr(dma_pkg::DMA_OFF_MODE_SEL, 32'hffffff03, r);
    bus_rd(dma_pkg::DMA_OFF_MODE_SEL, d, r);
    chk_val(d, 32'h3);
    $display("test reset_and_bus done");
    for (int j = 0; j < 2; j++) begin
      ms = j ? 6 : 0;
      setup(ms, 0, 1, 18);
      chk_cfg(ms, 0, 1, 18, 8'h80);
      tv <= 8'h22;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk_mode(mode, j ? dma_pkg::DMA_NET : dma_pkg::DMA_EXT);
      chk_cfg(ms, 0, 1, 18, 8'ha2);
    end
    setup(0, 0, 1, 19);
    chk_cfg(0, 0, 1, 19, 8'h81);
    chk_cfg(0, 0, 1, 19, 8'h83);
    $display("test stop_gating done");
    for (int i = 0; i < 40; i++) begin
      x = xs();
      ms = ms_tab[x[2:0] % 7];
      cs = (ms == 0 || ms == 6) ? cs_tab[x[5:3] % 5] : cs_tab[x[5:3] % 3];
      if (cs >= 10) asn = 1 | (x[6] ? 4 : 0);
      else if (ms == 7) asn = 2 | (x[6] ? 8 : 0);
      else if (ms == 2) asn = 2 | (x[6] ? 4 : 0);
      else asn = 2 * (1 + x[7:6] % 3);
      asn = asn | ((x[8] || ms == 2) ? 16 : 0);
      ns = x[9];
      v = x[23:16] | 8'h80;
      if (ms != 7) v[4] = 1'b0;
      setup(ms, cs, ns, asn);
      chk_cfg(ms, cs, ns, asn, v);
    end
    $display("test random_modes done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk_mode(mode, dma_pkg::DMA_EXT);
    bus_rd(dma_pkg::DMA_OFF_MODE_SEL, d, r);
    chk_val(d, 32'h0);
    $display("test second_reset done");
    complete_run();
  end
endmodule // dma_top_tb_top
`default_nettype wire
